// ---- verilog/cpu_status_map.svh ----
`ifndef CPU_STATUS_MAP_SVH
`define CPU_STATUS_MAP_SVH

// register byte offsets on the AXI4-Lite slave
`define STATUS_WORD_OFS 8'h00
`define CORE_CTRL_OFS 8'h04
`define NEST_CTRL_OFS 8'h08
// status word field positions
`define HALF_CARRY_POS 8
`define PRIO_MSB 7
`define PRIO_LSB 5
// core control field positions
`define PRIO_EXT_POS 3
// nesting control field positions
`define NEST_DIS_POS 15
// reset values and the all-ones priority mask
`define STATUS_WORD_RST 16'h0000
`define PRIO_RST 3'h0
`define PRIO_ALL_MASK 3'h7
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- verilog/cpu_status_pkg.sv ----
package cpu_status_pkg;
    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD
    } data_size_t;
    typedef enum logic {
        OP_ADD,
        OP_SUB
    } alu_op_t;
endpackage

// ---- verilog/cpu_status_flags.sv ----
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "cpu_status_map.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RQ1 - The status word holds a readable three-bit priority field in bits 7 to 5 that resets to 0.
// RQ2 - The priority field is a plain binary level, 110 meaning six, 101 five, down to zero.
// RQ3 - Priority field all ones masks every user interrupt and lets only traps through.
// RQ4 - Bit 8 half carry is set on carry or borrow at bit 3 for bytes or bit 7 for words, else 0.
// RQ5 - The priority bits ignore writes while the nesting-disable bit is one.
// RQ6 - A read-only fourth priority bit in core control joins the field to form the level.
// RQ7 - Writable writes to the priority bits change the level used for interrupt masking.
module cpu_status_flags #(
    parameter int ADDR_W = 8
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic ALU_VALID,
    input wire cpu_status_pkg::alu_op_t ALU_OP,
    input wire cpu_status_pkg::data_size_t ALU_SIZE,
    input wire logic [15:0] ALU_A,
    input wire logic [15:0] ALU_B,
    input wire logic ALU_CIN,
    input wire logic PRIO_LOAD,
    input wire logic [3:0] PRIO_LOAD_LEVEL,
    input wire logic [3:0] REQ_LEVEL,
    input wire logic REQ_TRAP,
    output logic [3:0] CPU_LEVEL,
    output logic USER_IRQ_MASKED,
    output logic TAKE_IRQ
);

////////////////////////////////////////////////////////////////////////////////
// state

logic [2:0] prio_q;
logic prio_ext_q;
logic half_carry_q;
logic nest_dis_q;
logic aw_held_q;
logic w_held_q;
logic [ADDR_W-1:0] awaddr_q;
logic [31:0] wdata_q;
logic [3:0] wstrb_q;
logic bvalid_q;
logic [1:0] bresp_q;
logic rvalid_q;
logic [31:0] rdata_q;
logic [1:0] rresp_q;

////////////////////////////////////////////////////////////////////////////////
// functions

// carry into the nibble or byte boundary: bit 4 (byte) or bit 8 (word) of the
// partial sum, which covers borrow as well since subtract is add of complement
function automatic logic half_carry(input cpu_status_pkg::alu_op_t op,
                                    input cpu_status_pkg::data_size_t sz,
                                    input logic [15:0] a, input logic [15:0] b,
                                    input logic cin);
    logic [8:0] part;
    logic [7:0] bb;
    part = 9'h000;
    bb = (op == cpu_status_pkg::OP_SUB) ? ~b[7:0] : b[7:0];
    if (sz == cpu_status_pkg::SIZE_BYTE) begin
        part = {5'h00, a[3:0]} + {5'h00, bb[3:0]} + {8'h00, cin};
        half_carry = part[4];
    end else begin
        part = {1'b0, a[7:0]} + {1'b0, bb} + {8'h00, cin};
        half_carry = part[8];
    end
    // on subtract a clear carry out means a borrow came in
    if (op == cpu_status_pkg::OP_SUB) begin
        half_carry = ~half_carry;
    end
endfunction

function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] addr, input logic [2:0] prio,
                                         input logic ext, input logic hc, input logic nd);
    read_mux = 32'h0000_0000;
    case (addr[7:0])
        `STATUS_WORD_OFS: begin
            read_mux[`HALF_CARRY_POS] = hc;
            read_mux[`PRIO_MSB:`PRIO_LSB] = prio; // see RQ1
        end
        `CORE_CTRL_OFS: begin
            read_mux[`PRIO_EXT_POS] = ext;
        end
        `NEST_CTRL_OFS: begin
            read_mux[`NEST_DIS_POS] = nd;
        end
        default: begin
            read_mux = 32'h0000_0000;
        end
    endcase
endfunction

function automatic logic addr_ok(input logic [ADDR_W-1:0] addr);
    addr_ok = (addr[7:0] == `STATUS_WORD_OFS) || (addr[7:0] == `CORE_CTRL_OFS) ||
              (addr[7:0] == `NEST_CTRL_OFS);
endfunction

////////////////////////////////////////////////////////////////////////////////
// write channel: address and data taken in either order, response after both

logic wr_go;
logic [ADDR_W-1:0] wr_addr;
logic [31:0] wr_data;
logic [3:0] wr_strb;

assign AWREADY = ~aw_held_q & ~bvalid_q;
assign WREADY = ~w_held_q & ~bvalid_q;
assign wr_addr = aw_held_q ? awaddr_q : AWADDR;
assign wr_data = w_held_q ? wdata_q : WDATA;
assign wr_strb = w_held_q ? wstrb_q : WSTRB;
assign wr_go = (aw_held_q | (AWVALID & AWREADY)) & (w_held_q | (WVALID & WREADY)) & ~bvalid_q;

always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
        aw_held_q <= 1'b0;
        awaddr_q <= '0;
    end else if (wr_go) begin
        aw_held_q <= 1'b0;
    end else if (AWVALID & AWREADY) begin
        aw_held_q <= 1'b1;
        awaddr_q <= AWADDR;
    end
end

always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
        w_held_q <= 1'b0;
        wdata_q <= 32'h0000_0000;
        wstrb_q <= 4'h0;
    end else if (wr_go) begin
        w_held_q <= 1'b0;
    end else if (WVALID & WREADY) begin
        w_held_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
    end
end

always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
        bvalid_q <= 1'b0;
        bresp_q <= `RESP_OKAY;
    end else if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (BREADY) begin
        bvalid_q <= 1'b0;
    end
end

assign BVALID = bvalid_q;
assign BRESP = bresp_q;

////////////////////////////////////////////////////////////////////////////////
// status word and control bits

logic sw_wr;
logic nd_wr;
logic field_wr;
logic hc_wr;
logic nest_dis_d;
logic [2:0] prio_d;
logic prio_ext_d;
logic half_carry_d;

assign sw_wr = wr_go && (wr_addr[7:0] == `STATUS_WORD_OFS);
assign nd_wr = wr_go && (wr_addr[7:0] == `NEST_CTRL_OFS) && wr_strb[1];
// the field sits in byte lane 0, the half carry in lane 1
assign field_wr = sw_wr && wr_strb[0] && !nest_dis_q; // see RQ5
assign hc_wr = sw_wr && wr_strb[1];

always_comb begin
    nest_dis_d = nest_dis_q;
    if (nd_wr) begin
        nest_dis_d = wr_data[`NEST_DIS_POS];
    end
end

// interrupt controller load wins over software, since it models entry/return
always_comb begin
    prio_d = prio_q;
    prio_ext_d = prio_ext_q;
    if (PRIO_LOAD) begin
        prio_d = PRIO_LOAD_LEVEL[2:0];
        prio_ext_d = PRIO_LOAD_LEVEL[3]; // see RQ6
    end else if (field_wr) begin
        prio_d = wr_data[`PRIO_MSB:`PRIO_LSB]; // see RQ7
    end
end

// alu update wins over a software write in the same cycle
always_comb begin
    half_carry_d = half_carry_q;
    if (ALU_VALID) begin
        half_carry_d = half_carry(ALU_OP, ALU_SIZE, ALU_A, ALU_B, ALU_CIN); // see RQ4
    end else if (hc_wr) begin
        half_carry_d = wr_data[`HALF_CARRY_POS];
    end
end

always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
        nest_dis_q <= 1'b0;
    end else begin
        nest_dis_q <= nest_dis_d;
    end
end

always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
        prio_q <= `PRIO_RST; // see RQ1
        prio_ext_q <= 1'b0;
    end else begin
        prio_q <= prio_d;
        prio_ext_q <= prio_ext_d;
    end
end

always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
        half_carry_q <= 1'b0;
    end else begin
        half_carry_q <= half_carry_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// priority level and masking

logic [3:0] level;
logic masked;

// plain binary: the level number is the extension bit above the field value
assign level = {prio_ext_q, prio_q}; // see RQ2 see RQ6
assign masked = prio_ext_q | (prio_q == `PRIO_ALL_MASK); // see RQ3
assign CPU_LEVEL = level;
assign USER_IRQ_MASKED = masked;
// unmasked user requests above the current level; traps always pass
assign TAKE_IRQ = REQ_TRAP | (~masked & (REQ_LEVEL > level)); // see RQ3 see RQ7

////////////////////////////////////////////////////////////////////////////////
// read channel

logic [31:0] rdata_d;
logic [1:0] rresp_d;
logic ar_hit;

assign ARREADY = ~rvalid_q;
assign ar_hit = ARVALID & ARREADY;

// unmapped offsets read as zero with an error response
always_comb begin
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_hit) begin
        rdata_d = read_mux(ARADDR, prio_q, prio_ext_q, half_carry_q, nest_dis_q);
        rresp_d = addr_ok(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end
end

always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
        rvalid_q <= 1'b0;
    end else if (ar_hit) begin
        rvalid_q <= 1'b1;
    end else if (RREADY) begin
        rvalid_q <= 1'b0;
    end
end

// data only moves on acceptance, so it stands while the answer waits
always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= `RESP_OKAY;
    end else begin
        rdata_q <= rdata_d;
        rresp_q <= rresp_d;
    end
end

assign RVALID = rvalid_q;
assign RDATA = rdata_q;
assign RRESP = rresp_q;

endmodule

// ---- verification/cpu_status_flags_assertions.sv ----
`timescale 1ns/100ps
module status_chk (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic PRIO_LOAD,
    input wire logic [3:0] PRIO_LOAD_LEVEL,
    input wire logic [3:0] REQ_LEVEL,
    input wire logic REQ_TRAP,
    input wire logic [3:0] CPU_LEVEL,
    input wire logic USER_IRQ_MASKED,
    input wire logic TAKE_IRQ,
    input wire logic BVALID,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA
);
default clocking @(posedge SYS_CLK); endclocking
default disable iff (!NRST);
reset_level_zero_a: assert property ($rose(NRST) |-> CPU_LEVEL == 4'h0)
    else $error("level not zero after reset");
level_mask_a: assert property (USER_IRQ_MASKED == (CPU_LEVEL[3] || CPU_LEVEL[2:0] == 3'h7))
    else $error("mask disagrees with level");
take_irq_a: assert property (TAKE_IRQ == (REQ_TRAP || (!USER_IRQ_MASKED && REQ_LEVEL > CPU_LEVEL)))
    else $error("take decision wrong");
load_level_a: assert property (PRIO_LOAD |=> CPU_LEVEL == $past(PRIO_LOAD_LEVEL))
    else $error("loaded level wrong");
level_cause_a: assert property ($changed(CPU_LEVEL) |-> $past(PRIO_LOAD) || $rose(BVALID))
    else $error("level changed without cause");
ext_read_only_a: assert property ($changed(CPU_LEVEL[3]) |-> $past(PRIO_LOAD))
    else $error("extension bit changed by software");
rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data not held");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cpu_status_flags status_chk chk_u (.SYS_CLK, .NRST, .PRIO_LOAD, .PRIO_LOAD_LEVEL,
    .REQ_LEVEL, .REQ_TRAP, .CPU_LEVEL, .USER_IRQ_MASKED, .TAKE_IRQ, .BVALID, .RVALID,
    .RREADY, .RDATA);

// ---- verification/tb.sv ----
`timescale 1ns/100ps
`include "cpu_status_map.svh"
module tb;
logic SYS_CLK = 0, NRST = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
logic ALU_VALID = 0, ALU_CIN = 0, PRIO_LOAD = 0, REQ_TRAP = 0, ext_m = 0, hc_m = 0;
logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
logic [31:0] WDATA = 32'h0, RDATA;
logic [3:0] WSTRB = 4'h0, PRIO_LOAD_LEVEL = 4'h0, REQ_LEVEL = 4'h0, CPU_LEVEL;
cpu_status_pkg::alu_op_t ALU_OP = cpu_status_pkg::OP_ADD;
cpu_status_pkg::data_size_t ALU_SIZE = cpu_status_pkg::SIZE_BYTE;
logic [15:0] ALU_A = 16'h0, ALU_B = 16'h0, lfsr_q = 16'h0002, r;
logic AWREADY, WREADY, BVALID, ARREADY, RVALID, USER_IRQ_MASKED, TAKE_IRQ;
logic [1:0] BRESP, RRESP, bq[$];
logic [2:0] prio_m = 3'h0;
logic [7:0] bx;
logic [8:0] sum;
logic [33:0] rq[$];
int failures = 0, compares = 0;
always #10 SYS_CLK = ~SYS_CLK;
cpu_status_flags dut_u (.*);
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
        failures++;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
    return lfsr_q;
endfunction
function automatic logic [33:0] st();
    return {`RESP_OKAY, 23'h0, hc_m, prio_m, 5'h0};
endfunction
// wr and rd each wait an edge first so a strobe dropped by the last one is never re-driven at once
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] e);
    @(posedge SYS_CLK);
    bq.push_back(e);
    AWADDR <= a; WDATA <= d; WSTRB <= s; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    do begin
        @(posedge SYS_CLK);
        if (AWREADY) AWVALID <= 0;
        if (WREADY) WVALID <= 0;
    end while (!BVALID);
    BREADY <= 0;
endtask
task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge SYS_CLK);
    rq.push_back(e);
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    do begin
        @(posedge SYS_CLK);
        if (ARREADY) ARVALID <= 0;
    end while (!RVALID);
    RREADY <= 0;
endtask
task automatic lv_chk();
    logic m = ext_m || prio_m == 3'h7;
    logic t = REQ_TRAP || (!m && REQ_LEVEL > {ext_m, prio_m});
    chk({28'h0, TAKE_IRQ, USER_IRQ_MASKED, CPU_LEVEL}, {28'h0, t, m, ext_m, prio_m});
endtask
task automatic rst();
    NRST <= 0;
    repeat (10) @(posedge SYS_CLK);
    NRST <= 1;
    {ext_m, hc_m, prio_m} = 5'h00;
endtask
task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
        $display("Run complete: PASS");
    end else begin
        $display("Run complete: FAIL");
    end
    $finish;
endtask
always @(posedge SYS_CLK) begin
    if (RVALID && RREADY && rq.size() > 0) chk({RRESP, RDATA}, rq.pop_front());
    if (BVALID && BREADY && bq.size() > 0) chk({32'h0, BRESP}, {32'h0, bq.pop_front()});
end
initial begin
    repeat (5000) @(posedge SYS_CLK);
    failures++;
    finish_test();
end
initial begin
    rst();
    rd(`STATUS_WORD_OFS, st());
    rd(`CORE_CTRL_OFS, 34'h0);
    rd(8'h0C, {`RESP_SLVERR, 32'h0});
    wr(8'h0C, 32'hFFFF_FFFF, 4'hF, `RESP_SLVERR);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
        r = rnd();
        REQ_LEVEL <= r[3:0];
        REQ_TRAP <= r[4];
        prio_m = 3'(i);
        wr(`STATUS_WORD_OFS, {24'h0, prio_m, 5'h1F}, 4'h1, `RESP_OKAY);
        rd(`STATUS_WORD_OFS, st());
        lv_chk();
    end
    $display("test levels done");
    wr(`NEST_CTRL_OFS, 32'h8000, 4'h2, `RESP_OKAY);
    wr(`STATUS_WORD_OFS, 32'h40, 4'h1, `RESP_OKAY);
    rd(`STATUS_WORD_OFS, st());
    rd(`NEST_CTRL_OFS, {2'h0, 32'h8000});
    wr(`NEST_CTRL_OFS, 32'h0, 4'h2, `RESP_OKAY);
    $display("test nesting done");
    @(posedge SYS_CLK);
    PRIO_LOAD <= 1;
    PRIO_LOAD_LEVEL <= 4'h9;
    @(posedge SYS_CLK);
    PRIO_LOAD <= 0;
    {ext_m, prio_m} = 4'h9;
    rd(`CORE_CTRL_OFS, {2'h0, 32'h8});
    wr(`STATUS_WORD_OFS, 32'h0, 4'h1, `RESP_OKAY);
    prio_m = 3'h0;
    rd(`STATUS_WORD_OFS, st());
    lv_chk();
    $display("test extension done");
    for (int i = 0; i < 12; i++) begin
        r = rnd();
        @(posedge SYS_CLK);
        ALU_VALID <= 1;
        ALU_OP <= cpu_status_pkg::alu_op_t'(r[0]);
        ALU_SIZE <= cpu_status_pkg::data_size_t'({1'b0, r[1]});
        ALU_CIN <= r[2];
        ALU_A <= rnd();
        ALU_B <= lfsr_q ^ r;
        @(posedge SYS_CLK);
        ALU_VALID <= 0;
        // a borrow is the inverse of the carry out of a + ~b + cin
        bx = r[0] ? ~ALU_B[7:0] : ALU_B[7:0];
        if (r[1]) begin
            sum = {1'b0, ALU_A[7:0]} + {1'b0, bx} + {8'h00, r[2]};
            hc_m = sum[8] ^ r[0];
        end else begin
            sum = {5'h00, ALU_A[3:0]} + {5'h00, bx[3:0]} + {8'h00, r[2]};
            hc_m = sum[4] ^ r[0];
        end
        rd(`STATUS_WORD_OFS, st());
    end
    $display("test half carry done");
    rst();
    rd(`STATUS_WORD_OFS, st());
    lv_chk();
    $display("test second reset done");
    finish_test();
end
endmodule
